// File: logic/pec_counter.sv
// Purpose: one 64-bit counter with software load and multi-step add
// Assumes: write and increment may coincide
// Notes:   a software write wins over an increment in the same cycle

`timescale 1ns/1ps
`default_nettype none

module pec_counter (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    // counter port
    pec_if.cnt        port
);
    import pec_pkg::*;

    logic [63:0] count;
    wire  [63:0] next_count;

    // the write taking priority keeps a software load exact
    assign next_count = port.wr_en  ? port.wr_data
                      : port.inc_en ? count + {60'h0, port.inc_amt}
                      : count;                            // see RULE15

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count <= PEC_COUNT_RESET;
        end else begin
            count <= next_count;
        end
    end

    assign port.value = count;
endmodule : pec_counter

`default_nettype wire

// File: logic/pec_if.sv
// Purpose: carries one increment request to a counter
// Assumes: single clock domain
// Notes:   the counter owns its storage and software access

`timescale 1ns/1ps
`default_nettype none

interface pec_if;
    logic        inc_en;
    logic [3:0]  inc_amt;
    logic        wr_en;
    logic [63:0] wr_data;
    logic [63:0] value;

    modport ctrl (
        output inc_en,
        output inc_amt,
        output wr_en,
        output wr_data,
        input  value
    );
    modport cnt (
        input  inc_en,
        input  inc_amt,
        input  wr_en,
        input  wr_data,
        output value
    );
endinterface : pec_if

`default_nettype wire

// File: logic/pec_pkg.sv
// Purpose: shared constants for the performance event counting block
// Assumes: register indices are the printed model-specific addresses
// Notes:   event and unit-mask codes select general-purpose sources

package pec_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int         PEC_AW             = 12;
    localparam int         PEC_DW             = 64;
    localparam logic [11:0] PEC_ADDR_RETIRED   = 12'h309;
    localparam logic [11:0] PEC_ADDR_CORE_CYC  = 12'h30A;
    localparam logic [11:0] PEC_ADDR_REF_CYC   = 12'h30B;
    localparam logic [11:0] PEC_ADDR_GP_SEL    = 12'h186;
    localparam logic [11:0] PEC_ADDR_GP_COUNT  = 12'h0C1;
    localparam logic [63:0] PEC_COUNT_RESET    = 64'h0;

    // ------------------------------------------------------------
    // selection field layout
    // ------------------------------------------------------------
    localparam int         PEC_SEL_EVT_LSB    = 0;
    localparam int         PEC_SEL_MASK_LSB   = 8;
    localparam int         PEC_SEL_EN_BIT     = 22;
    localparam logic [31:0] PEC_SEL_RESET      = 32'h0;

    // ------------------------------------------------------------
    // event and unit-mask codes
    // ------------------------------------------------------------
    localparam logic [7:0] PEC_EVT_LOAD_BLOCK = 8'h03;
    localparam logic [7:0] PEC_EVT_RETIRED    = 8'hC0;
    localparam logic [7:0] PEC_EVT_RENAME     = 8'hD2;
    localparam logic [7:0] PEC_UM_STORE_ADDR  = 8'h02;
    localparam logic [7:0] PEC_UM_STORE_VALUE = 8'h04;
    localparam logic [7:0] PEC_UM_OVERLAP     = 8'h08;
    localparam logic [7:0] PEC_UM_HOST_MODE   = 8'h08;
    localparam logic [7:0] PEC_UM_OTHER_SER   = 8'h10;

    // retirement width per cycle
    localparam int         PEC_RETIRE_W       = 3;

endpackage : pec_pkg

// File: logic/pec_top.sv
// Purpose: fixed-function and one general-purpose event counter
// Assumes: pipeline qualifiers arrive on clk_i; reference tick is a pin
// Notes:   register reads answer one cycle after the read strobe
//
// Function
// RULE1 - fixed counter 309H counts retired instructions
// RULE2 - multi-op instruction counts at last op
// RULE3 - keeps counting through interrupts and handlers
// RULE4 - fixed counter 30AH counts unhalted core cycles
// RULE5 - halt or monitor-wait means core halted
// RULE6 - 30BH counts reference cycles, unhalted, no stopclock
// RULE7 - reference counter advances at time-stamp rate
// RULE8 - 03H/02H counts loads blocked by store address
// RULE9 - 03H/04H counts loads blocked by store value
// RULE10 - 03H/08H counts partial overlap blocked loads
// RULE11 - overlap also counts misaligned loads under aligned store
// RULE12 - C0H/08H counts retirement in host mode
// RULE13 - D2H/10H counts other rename serialization stalls
// RULE14 - model events only on general-purpose counter
// RULE15 - counters add per-cycle amount, software read/write
//
// Chosen here: the strobed register port.

`timescale 1ns/1ps
`default_nettype none

module pec_top #(
    parameter int RETIRE_W = pec_pkg::PEC_RETIRE_W
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_b_i,
    // register port
    input  wire logic [pec_pkg::PEC_AW-1:0] reg_addr_i,
    input  wire logic [pec_pkg::PEC_DW-1:0] reg_wdata_i,
    input  wire logic                    reg_wr_i,
    input  wire logic                    reg_rd_i,
    output logic      [pec_pkg::PEC_DW-1:0] reg_rdata_o,
    // retirement qualifiers
    input  wire logic [RETIRE_W-1:0]     retire_valid_i,
    input  wire logic [RETIRE_W-1:0]     retire_last_op_i,
    input  wire logic                    host_mode_i,
    // core state
    input  wire logic                    halt_instruction_i,
    input  wire logic                    monitor_wait_instruction_i,
    input  wire logic                    thermal_stop_clock_i,
    input  wire logic                    tsc_tick_i,
    // load-blocking and rename qualifiers
    input  wire logic                    load_wait_store_address_i,
    input  wire logic                    load_wait_store_value_i,
    input  wire logic                    load_partial_overlap_i,
    input  wire logic                    store_aligned_i,
    input  wire logic [3:0]              load_size_i,
    input  wire logic                    load_aligned_to_store_i,
    input  wire logic                    load_misaligned_i,
    input  wire logic                    load_blocked_i,
    input  wire logic                    rename_other_serial_stalls_i
);
    import pec_pkg::*;

    // ------------------------------------------------------------
    // time-stamp tick synchroniser
    // ------------------------------------------------------------
    logic tick_meta;
    logic tick_sync;
    logic tick_prev;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tick_meta <= 1'b0;
            tick_sync <= 1'b0;
            tick_prev <= 1'b0;
        end else begin
            tick_meta <= tsc_tick_i;
            tick_sync <= tick_meta;
            tick_prev <= tick_sync;
        end
    end

    // one count per rising tick, independent of core frequency
    wire ref_edge = tick_sync & ~tick_prev;               // see RULE7

    // ------------------------------------------------------------
    // core state
    // ------------------------------------------------------------
    wire core_halted = halt_instruction_i
                     | monitor_wait_instruction_i;        // see RULE5
    wire core_run    = ~core_halted;                      // see RULE4
    wire ref_run     = core_run & ~thermal_stop_clock_i;  // see RULE6

    // ------------------------------------------------------------
    // retirement count
    // ------------------------------------------------------------
    // interrupt and trap flow retires like any other code, so no
    // qualifier here masks it
    logic [3:0] retired_now;

    always_comb begin
        retired_now = 4'h0;
        for (int i = 0; i < RETIRE_W; i++) begin
            if (retire_valid_i[i] && retire_last_op_i[i]) begin
                retired_now = retired_now + 4'h1;         // see RULE2
            end
        end
    end                                                   // see RULE3

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    wire hit_ret = (reg_addr_i == PEC_ADDR_RETIRED);
    wire hit_cor = (reg_addr_i == PEC_ADDR_CORE_CYC);
    wire hit_ref = (reg_addr_i == PEC_ADDR_REF_CYC);
    wire hit_sel = (reg_addr_i == PEC_ADDR_GP_SEL);
    wire hit_gp  = (reg_addr_i == PEC_ADDR_GP_COUNT);

    // ------------------------------------------------------------
    // general-purpose selection
    // ------------------------------------------------------------
    logic [31:0] gp_sel;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gp_sel <= PEC_SEL_RESET;
        end else if (reg_wr_i && hit_sel) begin
            gp_sel <= reg_wdata_i[31:0];
        end
    end

    wire [7:0] sel_evt  = gp_sel[PEC_SEL_EVT_LSB +: 8];
    wire [7:0] sel_mask = gp_sel[PEC_SEL_MASK_LSB +: 8];
    wire       sel_en   = gp_sel[PEC_SEL_EN_BIT];

    // small loads off the store start, or wider misaligned loads
    wire small_load  = (load_size_i == 4'h1) | (load_size_i == 4'h2);
    wire wide_load   = (load_size_i == 4'h4) | (load_size_i == 4'h8);
    wire align_case  = store_aligned_i & load_blocked_i
                     & ((small_load & ~load_aligned_to_store_i)
                     | (wide_load & load_misaligned_i));  // see RULE11
    wire overlap_evt = load_partial_overlap_i | align_case;

    wire is_ld = (sel_evt == PEC_EVT_LOAD_BLOCK);
    wire is_rt = (sel_evt == PEC_EVT_RETIRED);
    wire is_rn = (sel_evt == PEC_EVT_RENAME);

    // blocked loads may be counted once per blocked cycle, which
    // over-counts a load blocked for several cycles by design
    wire ev_sta = is_ld & (sel_mask == PEC_UM_STORE_ADDR)
                & load_wait_store_address_i;              // see RULE8
    wire ev_std = is_ld & (sel_mask == PEC_UM_STORE_VALUE)
                & load_wait_store_value_i;                // see RULE9
    wire ev_ovl = is_ld & (sel_mask == PEC_UM_OVERLAP)
                & overlap_evt;                            // see RULE10
    wire ev_rn  = is_rn & (sel_mask == PEC_UM_OTHER_SER)
                & rename_other_serial_stalls_i;           // see RULE13
    wire ev_hst = is_rt & (sel_mask == PEC_UM_HOST_MODE)
                & host_mode_i;                            // see RULE12

    wire [3:0] gp_amt = ev_hst ? retired_now
                      : {3'h0, ev_sta | ev_std | ev_ovl | ev_rn};

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    pec_if ret_p ();
    pec_if cor_p ();
    pec_if ref_p ();
    pec_if gp_p ();

    // fixed counters take only their own architectural sources
    assign ret_p.inc_en  = 1'b1;                          // see RULE1
    assign ret_p.inc_amt = retired_now;                   // see RULE14
    assign ret_p.wr_en   = reg_wr_i & hit_ret;            // see RULE15
    assign ret_p.wr_data = reg_wdata_i;

    assign cor_p.inc_en  = core_run;                      // see RULE4
    assign cor_p.inc_amt = 4'h1;
    assign cor_p.wr_en   = reg_wr_i & hit_cor;
    assign cor_p.wr_data = reg_wdata_i;

    assign ref_p.inc_en  = ref_run & ref_edge;            // see RULE6
    assign ref_p.inc_amt = 4'h1;
    assign ref_p.wr_en   = reg_wr_i & hit_ref;
    assign ref_p.wr_data = reg_wdata_i;

    assign gp_p.inc_en   = sel_en;                        // see RULE14
    assign gp_p.inc_amt  = gp_amt;
    assign gp_p.wr_en    = reg_wr_i & hit_gp;
    assign gp_p.wr_data  = reg_wdata_i;

    pec_counter u_ret (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .port    (ret_p)
    );
    pec_counter u_cor (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .port    (cor_p)
    );
    pec_counter u_ref (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .port    (ref_p)
    );
    pec_counter u_gp (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .port    (gp_p)
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped addresses read zero; data stands one cycle only
    wire [63:0] rd_mux = hit_ret ? ret_p.value
                       : hit_cor ? cor_p.value
                       : hit_ref ? ref_p.value
                       : hit_gp  ? gp_p.value
                       : hit_sel ? {32'h0, gp_sel}
                       : 64'h0;                           // see RULE15

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= 64'h0;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 64'h0;
        end
    end
endmodule : pec_top

`default_nettype wire

// File: sim/pec_top_properties.sv
// Purpose: port-level checks of the event counters
// Assumes: read data stands one cycle after the read strobe
// Notes:   counter steps are judged from back-to-back reads
`timescale 1ns/1ps
`default_nettype none
module pec_top_properties
    import pec_pkg::*;
#(
    parameter int RETIRE_W = PEC_RETIRE_W
) (
    input wire logic                clk_i,
    input wire logic                rst_b_i,
    input wire logic [PEC_AW-1:0]   reg_addr_i,
    input wire logic [PEC_DW-1:0]   reg_wdata_i,
    input wire logic                reg_wr_i,
    input wire logic                reg_rd_i,
    input wire logic [PEC_DW-1:0]   reg_rdata_o,
    input wire logic [RETIRE_W-1:0] retire_valid_i,
    input wire logic [RETIRE_W-1:0] retire_last_op_i,
    input wire logic                halt_instruction_i,
    input wire logic                monitor_wait_instruction_i,
    input wire logic                thermal_stop_clock_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire run = !halt_instruction_i && !monitor_wait_instruction_i;
    // two reads in a row: the step between answers is the first cycle's
    sequence rd2_s(a, c);
        reg_rd_i && reg_addr_i == a && c ##1 reg_rd_i && reg_addr_i == a;
    endsequence
    rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data not zero outside answer cycle");
    unmapped_rd_a: assert property (reg_rd_i && !(reg_addr_i inside
        {12'h309, 12'h30A, 12'h30B, 12'h186, 12'h0C1}) |=> reg_rdata_o == '0)
        else $error("unmapped read not zero");
    core_step_a: assert property (rd2_s(12'h30A, run) |=>
        reg_rdata_o == $past(reg_rdata_o) + 64'h1)
        else $error("core cycle counter did not step");
    core_halt_a: assert property (rd2_s(12'h30A, !run) |=>
        reg_rdata_o == $past(reg_rdata_o))
        else $error("core cycle counter moved while halted");
    retired_sum_a: assert property (rd2_s(12'h309, 1'b1) |=>
        reg_rdata_o == $past(reg_rdata_o) +
        64'($countones($past(retire_valid_i & retire_last_op_i, 2))))
        else $error("retired count step wrong");
    ref_stop_a: assert property (rd2_s(12'h30B, thermal_stop_clock_i || !run)
        |=> reg_rdata_o == $past(reg_rdata_o))
        else $error("reference counter moved while stopped");
    write_load_a: assert property (reg_wr_i ##1 reg_rd_i &&
        reg_addr_i == $past(reg_addr_i) &&
        reg_addr_i inside {12'h309, 12'h30A, 12'h30B, 12'h0C1}
        |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("written value not read back");
    sel_upper_a: assert property (reg_rd_i && reg_addr_i == 12'h186
        |=> reg_rdata_o[63:32] == 32'h0)
        else $error("selection upper half not zero");
endmodule : pec_top_properties
bind pec_top pec_top_properties #(.RETIRE_W(RETIRE_W)) i_chk (.*);
`default_nettype wire

// File: sim/pec_top_tb.sv
// Purpose: random and corner tests of the event counters
// Assumes: register reads answer one cycle after the strobe
// Notes:   reference ticks toggle at random; the tick test drives clean
//          pulses
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    fail_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module pec_top_tb;
    import pec_pkg::*;
    logic        clk_i = 1'b0, rst_b_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h0;
    logic [63:0] reg_wdata_i = 64'h0, reg_rdata_o;
    logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [2:0]  retire_valid_i = 3'h0, retire_last_op_i = 3'h0;
    logic        host_mode_i = 1'b0, halt_instruction_i = 1'b0;
    logic        monitor_wait_instruction_i = 1'b0;
    logic        thermal_stop_clock_i = 1'b0, tsc_tick_i = 1'b0;
    logic        load_wait_store_address_i = 1'b0;
    logic        load_wait_store_value_i = 1'b0;
    logic        load_partial_overlap_i = 1'b0, store_aligned_i = 1'b0;
    logic [3:0]  load_size_i = 4'h1;
    logic        load_aligned_to_store_i = 1'b0, load_misaligned_i = 1'b0;
    logic        load_blocked_i = 1'b0, rename_other_serial_stalls_i = 1'b0;
    int          fail_count = 0, check_count = 0;
    bit          rnd = 1'b0;
    // pin history: a rise two cycles back is the edge counted this cycle
    logic [2:0]  tick_h = 3'h0;
    logic [15:0] code = 16'h0;
    logic [63:0] d0;
    logic [11:0] addrs [5] = '{12'h309, 12'h30A, 12'h30B, 12'h0C1, 12'h30C};
    // last code is unsupported and must count nothing
    logic [15:0] codes [6] = '{16'h0302, 16'h0304, 16'h0308, 16'hC008,
                               16'hD210, 16'h0310};
    always #25 clk_i = ~clk_i;
    pec_top i_dut (.*);
    // ------------------------------------------------------------
    // random pipeline qualifiers
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        tick_h <= {tick_h[1:0], tsc_tick_i};
        if (rnd) begin
            {retire_valid_i, retire_last_op_i, host_mode_i} <= 7'($urandom);
            tsc_tick_i                 <= 1'($urandom);
            halt_instruction_i         <= ($urandom % 4) == 0;
            monitor_wait_instruction_i <= ($urandom % 4) == 0;
            thermal_stop_clock_i       <= 1'($urandom);
            {load_wait_store_address_i, load_wait_store_value_i,
             load_partial_overlap_i, store_aligned_i, load_aligned_to_store_i,
             load_misaligned_i, load_blocked_i,
             rename_other_serial_stalls_i} <= 8'($urandom);
            load_size_i                <= 4'h1 << ($urandom % 4);
        end
    end
    // step a counter takes from the inputs of the current cycle
    function automatic logic [63:0] exp_delta(input logic [11:0] a);
        logic [63:0] r;
        logic        ov;
        r  = 64'($countones(retire_valid_i & retire_last_op_i));
        ov = load_partial_overlap_i || (store_aligned_i && load_blocked_i &&
             ((load_size_i < 4'h4 && !load_aligned_to_store_i) ||
              (load_size_i > 4'h2 && load_misaligned_i)));
        exp_delta = 64'h0;
        if (a == 12'h309) exp_delta = r;
        if (a == 12'h30A)
            exp_delta = 64'(!halt_instruction_i && !monitor_wait_instruction_i);
        if (a == 12'h30B)
            exp_delta = 64'(tick_h[1] && !tick_h[2] && !thermal_stop_clock_i &&
                            !halt_instruction_i &&
                            !monitor_wait_instruction_i);
        if (a == 12'h0C1) begin
            case (code)
                16'h0302: exp_delta = 64'(load_wait_store_address_i);
                16'h0304: exp_delta = 64'(load_wait_store_value_i);
                16'h0308: exp_delta = 64'(ov);
                16'hC008: exp_delta = host_mode_i ? r : 64'h0;
                16'hD210: exp_delta = 64'(rename_other_serial_stalls_i);
                default:  exp_delta = 64'h0;
            endcase
        end
    endfunction : exp_delta
    // optional write, then two reads with no gap
    task automatic op(input logic [11:0] a, input logic [63:0] v,
                      input bit w, output logic [63:0] d);
        logic [63:0] d1, e;
        bit          blk, oth;
        if (w) begin
            @(posedge clk_i);
            {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, v};
        end
        @(posedge clk_i);
        {reg_wr_i, reg_rd_i, reg_addr_i} <= {1'b0, 1'b1, a};
        @(negedge clk_i);
        e = exp_delta(a);
        @(posedge clk_i);
        @(negedge clk_i);
        d = reg_rdata_o;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_i);
        d1  = reg_rdata_o;
        blk = a == 12'h0C1 && code[15:8] == 8'h03;
        oth = a == 12'h0C1 && !blk;
        case (a)
            12'h309: `CHK("retired", e, d1 - d)
            12'h30A: `CHK("core", e, d1 - d)
            12'h30B: `CHK("ref", e, d1 - d)
            12'h186: `CHK("select", {32'h0, v[31:0]}, d)
            12'h0C1: ;
            default: `CHK("unmapped", 64'h0, d | d1)
        endcase
        if (blk) `CHK("blk", e, d1 - d)
        if (oth) `CHK("gp", e, d1 - d)
        if (w && a != 12'h30C && a != 12'h186) `CHK("load", v, d)
    endtask : op
    task automatic end_of_test();
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(32'h0343));
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rnd     <= 1'b1;
        foreach (codes[k]) begin
            code = codes[k];
            op(12'h186, {32'($urandom), 16'h0040, code[7:0], code[15:8]},
               1'b1, d0);
            op(12'h0C1, 64'h0, 1'b1, d0);
            repeat (12) op(addrs[$urandom % 5], {$urandom, $urandom} |
                           {64{$urandom % 8 == 0}}, 1'($urandom), d0);
        end
        // enable clear: a supported selection must count nothing
        op(12'h186, {48'h0, 8'h02, 8'h03}, 1'b1, d0);
        code = 16'h0;
        repeat (4) op(12'h0C1, 64'h0, 1'($urandom), d0);
        // ticks count only when running; clock count differs from ticks
        rnd <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            @(posedge clk_i);
            tsc_tick_i                 <= 1'b0;
            thermal_stop_clock_i       <= c == 1;
            halt_instruction_i         <= c == 2;
            monitor_wait_instruction_i <= c == 3;
            op(12'h30B, 64'h0, 1'b1, d0);
            repeat (3) begin
                repeat (4) @(posedge clk_i) tsc_tick_i <= 1'b1;
                repeat (4) @(posedge clk_i) tsc_tick_i <= 1'b0;
            end
            repeat (6) @(posedge clk_i);
            op(12'h30B, 64'h0, 1'b0, d0);
            `CHK("ticks", (c == 0) ? 64'h3 : 64'h0, d0)
        end
        end_of_test();
    end
endmodule : pec_top_tb
`default_nettype wire
